// ### rtl/pcm_pkg.sv
/*
 Package for the per-channel mode and driver-control decoder.
 Holds register offsets, field layouts, reset values and decode enums.
 Assumes a single hclk domain and an AHB-Lite slave register port.
*/
package pcm_pkg;

   localparam int NUM_CH = 2;

   // Register byte offsets (one word per channel, then a status word and a calibration status word)
   localparam logic [7:0] CFG0_OFS = 8'h00;
   localparam logic [7:0] CFG1_OFS = 8'h04;
   localparam logic [7:0] STAT_OFS = 8'h08;
   localparam logic [7:0] CAL_OFS = 8'h0c;

   // Field positions inside a channel config word
   localparam int F_LLS = 0;
   localparam int F_PFE = 1;
   localparam int F_FMB = 2;
   localparam int F_MMB = 3;
   localparam int F_RS2 = 4;
   localparam int F_TMS = 5;
   localparam int F_VHS = 6;
   localparam int F_LDD = 7;
   localparam int F_SLW = 8;
   localparam int F_DRP = 10;
   localparam int F_ORC = 13;
   localparam int CFG_W = 17;

   // Reset values of the serial fields
   localparam logic [1:0] SLEW_RST = 2'h0;
   localparam logic [2:0] DROOP_RST = 3'h0;
   localparam logic [3:0] ORC_RST = 4'h8;
   localparam logic [2:0] DROOP_DEFAULT = 3'h1;

   // Slew percent per code, droop in tenths of a percent per step
   localparam logic [6:0] SLEW_PCT_STEP = 7'h19;
   localparam logic [6:0] SLEW_PCT_FULL = 7'h64;
   localparam logic [6:0] DROOP_TENTHS_STEP = 7'h0f;
   localparam int ORC_STEP_MOHM = 360;

   localparam logic [1:0] HRESP_OKAY = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [1:0]
   {
      SEC_LOW_LEAK = 2'h0,
      SEC_AVAIL = 2'h1
   } pcm_sec_t;

   typedef enum logic [2:0]
   {
      PMU_HIZ = 3'h0,
      PMU_FVMI = 3'h1,
      PMU_FVMV = 3'h2,
      PMU_FIMI = 3'h3,
      PMU_FIMV = 3'h4,
      PMU_FORCE_NONE_MEASURE_NONE = 3'h5,
      PMU_FNMV = 3'h6
   } pcm_pmu_t;

   typedef enum logic [2:0]
   {
      DRV_LOW_LEAK = 3'h0,
      DRV_LOW = 3'h1,
      DRV_HIGH = 3'h3,
      DRV_TERM = 3'h2,
      DRV_HIZ_RCV = 3'h6,
      DRV_VHH = 3'h7
   } pcm_drv_t;

   // Stored serial bits for one channel
   typedef struct packed
   {
      logic [3:0] output_resistance_code;
      logic [2:0] droop_field;
      logic [1:0] slew_field;
      logic load_disable_bit;
      logic vhh_serial_enable;
      logic termination_select;
      logic range_select_bit2;
      logic measure_mode_bit;
      logic force_mode_bit;
      logic param_force_enable;
      logic low_leak_serial_bit;
   } pcm_cfg_t;

   localparam pcm_cfg_t CFG_RST = '{ORC_RST, DROOP_RST, SLEW_RST,
      1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};

   // Live high-speed and external pins for one channel
   typedef struct packed
   {
      logic low_leak_pin_n;
      logic vhh_pin_enable_n;
      logic receive_select_in;
      logic data_in;
   } pcm_pins_t;

   // Decoded channel state
   typedef struct packed
   {
      pcm_sec_t drv_sec;
      pcm_sec_t cmp_sec;
      pcm_sec_t load_sec;
      pcm_pmu_t pmu_state;
      pcm_drv_t drv_sel;
      logic cal_mode;
      logic range_b_forced;
      logic clamps_on;
      logic comparators_on;
      logic [6:0] slew_pct;
      logic [6:0] droop_tenths;
      logic signed [4:0] orc_steps;
   } pcm_dec_t;

endpackage

// ### rtl/pcm_decoder.sv
/*
 Dual-channel pin mode and driver-control decoder with AHB-Lite registers.
 Assumes the external pins are asynchronous to hclk; the decode itself is
 combinational from stored bits and the raw pins.
*/
`timescale 1ns/100ps

// Functional notes
// - Low-leak pin low forces low leak, PMU hiz
// - Force-enable: PMU on, section low leak
// - Calibration mode bits decode four PMU states
// - Calibration keeps normal section controls except the driver, held low leak in FVMI
// - Calibration with range bit 2 set: no range A, range B
// - Receive low: data selects low/high level
// - Receive high: hiz or term by select
// - VHH by serial bit with receive high, or pin low with serial bit clear
// - Serial low-leak overrides; channels independent
// - Slew field sets 100/75/50/25 percent
// - Slew field resets to zero
// - Droop field 1.5 percent per step
// - Droop resets zero; default code 001
// - Output resistance adjusted in 360 mohm steps
// - Hiz receive keeps clamps and comparators
// - Resistance code offset binary, resets 1000
module pcm_decoder
#(
   parameter int NCH = pcm_pkg::NUM_CH
)
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic clk_en,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic [1:0] hresp,
   input wire pcm_pkg::pcm_pins_t [NCH-1:0] pins,
   output pcm_pkg::pcm_dec_t [NCH-1:0] dec
);
   import pcm_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // Bus slave

   pcm_cfg_t [NCH-1:0] cfg_q;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [31:0] hrdata_q;
   logic [NCH-1:0] llp_s1_q;
   logic [NCH-1:0] llp_s2_q;
   logic addr_ok;
   logic [31:0] rd_d;

   // Zero-wait slave; single words only, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = HRESP_OKAY;
   assign hrdata = hrdata_q;
   assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ);

   // Byte offset to channel number, -1 style miss as NCH
   function automatic int ch_of(input logic [7:0] a);
      if (a == CFG0_OFS)
         return 0;
      else if (a == CFG1_OFS)
         return 1;
      else
         return NCH;
   endfunction

   // Latch write address phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end
      else if (clk_en)
      begin
         wr_pend_q <= addr_ok && hwrite;
         wr_addr_q <= haddr[7:0];
      end
   end

   // Config store; reset puts slew and droop at zero, resistance at 1000
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < NCH; i++)
            cfg_q[i] <= CFG_RST;
      end
      else if (clk_en && wr_pend_q && ch_of(wr_addr_q) < NCH)
      begin
         cfg_q[ch_of(wr_addr_q)] <= hwdata[CFG_W-1:0];
      end
   end

   // Read mux; unmapped addresses return zero
   always_comb
   begin
      rd_d = 32'h0000_0000;
      if (ch_of(haddr[7:0]) < NCH)
         rd_d[CFG_W-1:0] = cfg_q[ch_of(haddr[7:0])];
      else if (haddr[7:0] == STAT_OFS)
      begin
         for (int i = 0; i < NCH; i++)
         begin
            rd_d[4*i +: 3] = dec[i].drv_sel;
            rd_d[4*i+3] = llp_s2_q[i];
         end
      end
      else if (haddr[7:0] == CAL_OFS)
      begin
         for (int i = 0; i < NCH; i++)
         begin
            rd_d[4*i] = dec[i].cal_mode;
            rd_d[4*i+1] = dec[i].range_b_forced;
         end
      end
   end

   // Read data captured at address phase, shown in data phase
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         hrdata_q <= 32'h0000_0000;
      else if (clk_en && addr_ok && !hwrite)
         hrdata_q <= rd_d;
   end

   // Status only: pin level synchronised for software readback
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         llp_s1_q <= '1;
         llp_s2_q <= '1;
      end
      else if (clk_en)
      begin
         for (int i = 0; i < NCH; i++)
            llp_s1_q[i] <= pins[i].low_leak_pin_n;
         llp_s2_q <= llp_s1_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-channel decode; pins act with no clock so low leak is immediate

   for (genvar c = 0; c < NCH; c++)
   begin : g_ch
      pcm_cfg_t s;
      pcm_pins_t p;
      assign s = cfg_q[c];
      assign p = pins[c];

      // Mode table; every channel has its own copy
      always_comb
      begin
         dec[c] = '0;
         dec[c].drv_sec = SEC_LOW_LEAK;
         dec[c].cmp_sec = SEC_LOW_LEAK;
         dec[c].load_sec = SEC_LOW_LEAK;
         dec[c].pmu_state = PMU_HIZ;
         dec[c].drv_sel = DRV_LOW_LEAK;
         if (!p.low_leak_pin_n)
         begin
            dec[c].pmu_state = PMU_HIZ;
         end
         else if (s.param_force_enable)
         begin
            case ({s.force_mode_bit, s.measure_mode_bit})
               2'b00: dec[c].pmu_state = PMU_FVMI;
               2'b01: dec[c].pmu_state = PMU_FVMV;
               2'b10: dec[c].pmu_state = PMU_FIMI;
               default: dec[c].pmu_state = PMU_FIMV;
            endcase
         end
         else if (!s.low_leak_serial_bit)
         begin
            dec[c].cmp_sec = SEC_AVAIL;
            dec[c].load_sec = SEC_AVAIL;
            dec[c].drv_sec = SEC_AVAIL;
            case ({s.force_mode_bit, s.measure_mode_bit})
               2'b00:
               begin
                  dec[c].pmu_state = PMU_FVMI;
                  dec[c].drv_sec = SEC_LOW_LEAK;
               end
               2'b01: dec[c].pmu_state = PMU_FIMV;
               2'b10: dec[c].pmu_state = PMU_FORCE_NONE_MEASURE_NONE;
               default: dec[c].pmu_state = PMU_FNMV;
            endcase
            dec[c].cal_mode = (dec[c].pmu_state != PMU_FORCE_NONE_MEASURE_NONE);
            // Range A withheld while calibrating with range_select_bit2 set
            dec[c].range_b_forced = dec[c].cal_mode &&
               s.range_select_bit2;
         end
         else
         begin
            // Serial low leak with force off: PMU measures only with the measure bit set, else force none measure none
            dec[c].pmu_state = s.measure_mode_bit ? PMU_FNMV : PMU_FORCE_NONE_MEASURE_NONE;
         end

         // Driver mux uses normal controls in any mode when available
         if (!p.low_leak_pin_n || s.low_leak_serial_bit ||
             dec[c].drv_sec == SEC_LOW_LEAK)
            dec[c].drv_sel = DRV_LOW_LEAK;
         else if ((s.vhh_serial_enable && p.receive_select_in) ||
                  (!s.vhh_serial_enable && !p.vhh_pin_enable_n))
            dec[c].drv_sel = DRV_VHH;
         else if (!p.receive_select_in)
            dec[c].drv_sel = p.data_in ? DRV_HIGH : DRV_LOW;
         else
            dec[c].drv_sel = s.termination_select ? DRV_TERM
                                                  : DRV_HIZ_RCV;

         // Clamps only in hiz receive; comparators on while the comparator section is available
         dec[c].clamps_on = (dec[c].drv_sel == DRV_HIZ_RCV);
         dec[c].comparators_on = (dec[c].cmp_sec == SEC_AVAIL);

         // Analog trims from stored fields
         dec[c].slew_pct = SLEW_PCT_FULL -
            7'(SLEW_PCT_STEP * s.slew_field);
         dec[c].droop_tenths = 7'(DROOP_TENTHS_STEP *
            s.droop_field);
         dec[c].orc_steps = $signed({1'b0, s.output_resistance_code})
            - $signed(5'(ORC_RST));
      end

      // Mode decode follows the pin with no clock in between
      chk_pin_low_leak: assert property (@(posedge hclk)
         disable iff (!hresetn)
         !p.low_leak_pin_n |-> dec[c].drv_sel == DRV_LOW_LEAK &&
         dec[c].pmu_state == PMU_HIZ)
         else $error("low-leak pin did not force low leak");
      chk_force_enable: assert property (@(posedge hclk)
         disable iff (!hresetn)
         p.low_leak_pin_n && s.param_force_enable |->
         dec[c].load_sec == SEC_LOW_LEAK && dec[c].pmu_state != PMU_HIZ)
         else $error("force enable decode wrong");
      chk_cal_range: assert property (@(posedge hclk)
         disable iff (!hresetn)
         dec[c].range_b_forced |-> dec[c].cal_mode && s.range_select_bit2)
         else $error("range B forced outside calibration");

      // Calibration entry judged from the raw bits, not from cal_mode
      chk_cal_entry: assert property (@(posedge hclk)
         disable iff (!hresetn)
         p.low_leak_pin_n && !s.param_force_enable &&
         !s.low_leak_serial_bit &&
         !(s.force_mode_bit && !s.measure_mode_bit) |->
         dec[c].cal_mode && dec[c].range_b_forced == s.range_select_bit2)
         else $error("calibration decode wrong");
      // Only the force-nothing code leaves calibration
      chk_normal_mode: assert property (@(posedge hclk)
         disable iff (!hresetn)
         p.low_leak_pin_n && !s.param_force_enable &&
         !s.low_leak_serial_bit && s.force_mode_bit &&
         !s.measure_mode_bit |->
         dec[c].pmu_state == PMU_FORCE_NONE_MEASURE_NONE && !dec[c].cal_mode &&
         dec[c].drv_sec == SEC_AVAIL && dec[c].load_sec == SEC_AVAIL)
         else $error("normal mode decode wrong");
      chk_serial_leak: assert property (@(posedge hclk)
         disable iff (!hresetn)
         s.low_leak_serial_bit |-> dec[c].drv_sel == DRV_LOW_LEAK)
         else $error("serial low leak ignored");

      // Driver mux rows, each from its own inputs
      chk_data_level: assert property (@(posedge hclk)
         disable iff (!hresetn)
         dec[c].drv_sec == SEC_AVAIL && !p.receive_select_in &&
         p.vhh_pin_enable_n && !s.low_leak_serial_bit |->
         dec[c].drv_sel == (p.data_in ? DRV_HIGH : DRV_LOW))
         else $error("data level select wrong");
      chk_receive_mode: assert property (@(posedge hclk)
         disable iff (!hresetn)
         dec[c].drv_sec == SEC_AVAIL && !s.low_leak_serial_bit &&
         p.receive_select_in && !s.vhh_serial_enable &&
         p.vhh_pin_enable_n |->
         dec[c].drv_sel == (s.termination_select ? DRV_TERM : DRV_HIZ_RCV))
         else $error("receive select wrong");
      chk_vhh_select: assert property (@(posedge hclk)
         disable iff (!hresetn)
         dec[c].drv_sel == DRV_VHH |-> (s.vhh_serial_enable ?
         p.receive_select_in : !p.vhh_pin_enable_n))
         else $error("VHH selected without cause");
      chk_vhh_cause: assert property (@(posedge hclk)
         disable iff (!hresetn)
         dec[c].drv_sec == SEC_AVAIL && !s.low_leak_serial_bit &&
         (s.vhh_serial_enable ? p.receive_select_in : !p.vhh_pin_enable_n)
         |-> dec[c].drv_sel == DRV_VHH)
         else $error("VHH request ignored");
      // A receiving pin must still be watched
      chk_receive_clamps: assert property (@(posedge hclk)
         disable iff (!hresetn)
         dec[c].drv_sel == DRV_HIZ_RCV |->
         dec[c].clamps_on && dec[c].comparators_on)
         else $error("receive lost clamps or comparators");

      // Trim fields: reset values and end points
      chk_slew_reset: assert property (@(posedge hclk)
         $rose(hresetn) |-> s.slew_field == SLEW_RST &&
         s.droop_field == DROOP_RST &&
         s.output_resistance_code == ORC_RST)
         else $error("trim fields not at reset value");
      chk_slew_pct: assert property (@(posedge hclk)
         disable iff (!hresetn)
         s.slew_field == 2'h3 |-> dec[c].slew_pct == SLEW_PCT_STEP)
         else $error("slowest slew not quarter rate");
      chk_slew_full: assert property (@(posedge hclk)
         disable iff (!hresetn)
         s.slew_field == SLEW_RST |-> dec[c].slew_pct == SLEW_PCT_FULL)
         else $error("reset slew code not full rate");
      chk_orc_nominal: assert property (@(posedge hclk)
         disable iff (!hresetn)
         s.output_resistance_code == ORC_RST |-> dec[c].orc_steps == 5'sh0)
         else $error("nominal resistance code not zero offset");
   end

   // Write as two steps: a taken address phase, then a live data phase
   sequence s_wr_addr0;
      clk_en && addr_ok && hwrite && haddr[7:0] == CFG0_OFS;
   endsequence
   sequence s_wr_data;
      clk_en;
   endsequence

   // Write lands one edge after its address phase
   chk_write_land: assert property (@(posedge hclk)
      disable iff (!hresetn)
      s_wr_addr0 ##1 s_wr_data |=> cfg_q[0] == $past(hwdata[CFG_W-1:0]))
      else $error("config write did not land");

   // Low clock enable must leave every stored config bit alone
   chk_freeze_cfg: assert property (@(posedge hclk) disable iff (!hresetn)
      !clk_en |=> $stable(cfg_q))
      else $error("config changed while clock enable low");

   // Read data holds between read address phases
   chk_rdata_hold: assert property (@(posedge hclk) disable iff (!hresetn)
      !(clk_en && addr_ok && !hwrite) |=> $stable(hrdata))
      else $error("read data changed outside a read");

endmodule // pcm_decoder

// ### sim/pcm_tgen.sv
/*
 Timing-generator model: drives the live pins of both channels.
 Assumes the bench hands it pin requests; they land on hclk.
*/
`timescale 1ns/100ps
module pcm_tgen
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire pcm_pkg::pcm_pins_t [1:0] req,
   output pcm_pkg::pcm_pins_t [1:0] pins
);
   import pcm_pkg::*;
   // Low-leak pin idles high so the channel may leave low leak
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         pins <= {2{4'b1100}};
      else
         pins <= req;
endmodule // pcm_tgen

// ### sim/pcm_decoder_tb_top.sv
/*
 Self-checking bench for the pin mode decoder: bus tasks, decode tables.
 Assumes a zero-wait register slave and the pin model beside it.
*/
`timescale 1ns/100ps
module pcm_decoder_tb_top;
   import pcm_pkg::*;
   logic hclk, hresetn, hsel, hwrite, hreadyout, ll, en;
   logic [31:0] haddr, hwdata, hrdata, rd, w;
   logic [1:0] htrans, hresp;
   logic [2:0] hsize;
   pcm_pins_t [1:0] req, pins;
   pcm_dec_t [1:0] dec;
   int err_total, n_checks, cyc;
   pcm_pmu_t pcal[4] = '{PMU_FVMI, PMU_FIMV, PMU_FORCE_NONE_MEASURE_NONE, PMU_FNMV};
   // Driver rows: vhs, tms, vhh pin, receive, data
   logic [4:0] drow[6] = '{5'h14, 5'h15, 5'h06, 5'h0f, 5'h16, 5'h01};
   pcm_drv_t dexp[6] = '{DRV_LOW, DRV_HIGH, DRV_HIZ_RCV, DRV_TERM,
      DRV_VHH, DRV_VHH};

   pcm_decoder dut (.hclk(hclk), .hresetn(hresetn), .clk_en(en),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .pins(pins), .dec(dec));
   pcm_tgen tgen (.hclk(hclk), .hresetn(hresetn), .req(req),
      .pins(pins));

   ////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial
   begin
      hclk = 1'b0;
      forever #10 hclk = ~hclk;
   end

   always @(posedge hclk)
   begin
      cyc <= cyc + 1;
      if (cyc == 4000)
      begin
         err_total++;
         summarize();
      end
   end

   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
      input string m);
      n_checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // Bounded wait, slave is zero-wait but never trusted to be
   task automatic edge_rdy;
      int n;
      n = 0;
      do
      begin
         @(posedge hclk);
         n++;
      end
      while (hreadyout !== 1'b1 && n < 50);
   endtask

   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= HTRANS_NONSEQ;
      hwrite <= wr;
      haddr <= {24'h0, a};
      edge_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      edge_rdy();
      rd = hrdata;
      chk(32'(hresp), 32'(HRESP_OKAY), "hresp");
   endtask

   // Two edges let pin requests and config writes both land
   task automatic settle;
      repeat (2) @(posedge hclk);
      #2;
   endtask

   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {hsel, hwrite, haddr, hwdata, htrans, err_total, n_checks} = '0;
      {cyc, hresetn} = '0;
      hsize = 3'h2;
      en = 1'b1;
      req = {2{4'b1100}};
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, CFG0_OFS, 32'h0);
      chk(rd, 32'h0001_0000, "cfg0 reset");
      bus(1'b0, CFG1_OFS, 32'h0);
      chk(rd, 32'h0001_0000, "cfg1 reset");
      bus(1'b0, 8'h40, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      $display("test reset done");
      for (int i = 0; i < 8; i++)
      begin
         w = (32'(i % 4) << 8) | (32'(i) << 10) | (32'(2 * i) << 13);
         bus(1'b1, CFG0_OFS, w);
         bus(1'b0, CFG0_OFS, 32'h0);
         chk(rd, w, "readback");
         settle();
         chk(32'(dec[0].slew_pct), 32'(100 - 25 * (i % 4)), "slew");
         chk(32'(dec[0].droop_tenths), 32'(15 * i), "droop");
         chk({{27{dec[0].orc_steps[4]}}, dec[0].orc_steps},
            32'(2 * i - 8), "ohm");
      end
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      bus(1'b0, CFG0_OFS, 32'h0);
      chk(rd, 32'h0001_0000, "cfg0 rerun");
      $display("test fields done");
      for (int m = 0; m < 8; m++)
      begin
         w = 32'h10 | (m < 4 ? 32'h2 : 32'h0);
         w = w | (32'(m[1]) << 2) | (32'(m[0]) << 3);
         bus(1'b1, CFG0_OFS, w);
         settle();
         ll = (m <= 4);
         w = m < 4 ? 32'(PMU_FVMI) + m : 32'(pcal[m - 4]);
         chk(32'(dec[0].pmu_state), w, "pmu");
         chk(32'(dec[0].drv_sec), ll ? 32'(SEC_LOW_LEAK) : 32'(SEC_AVAIL),
            "drv sec");
         chk(32'({dec[0].cmp_sec, dec[0].load_sec}), m < 4 ? 32'h0 : 32'h5,
            "cmp load");
         chk(32'(dec[0].drv_sel), ll ? 32'(DRV_LOW_LEAK) : 32'(DRV_LOW),
            "cal drv");
         chk(32'({dec[0].cal_mode, dec[0].range_b_forced}),
            (m >= 4 && m != 6) ? 32'h3 : 32'h0, "range");
      end
      // Ch0 calibrating with range B, ch1 calibrating from reset bits
      bus(1'b0, CAL_OFS, 32'h0);
      chk(rd, 32'h13, "cal status");
      $display("test modes done");
      bus(1'b1, CFG1_OFS, 32'h8);
      settle();
      req[0] <= 4'b0100;
      @(posedge hclk);
      #2;
      chk(32'(dec[0].pmu_state), 32'(PMU_HIZ), "pin leak");
      chk(32'({dec[0].drv_sec, dec[0].cmp_sec, dec[0].load_sec,
         dec[0].drv_sel}), 32'h0, "pin leak sec");
      chk(32'(dec[1].pmu_state), 32'(PMU_FIMV), "ch1 alone");
      // Synced pin needs a few edges before software sees it
      settle();
      bus(1'b0, STAT_OFS, 32'h0);
      chk(rd, (32'h8 | 32'(DRV_LOW)) << 4, "status");
      req[0] <= 4'b1100;
      bus(1'b1, CFG1_OFS, 32'h9);
      settle();
      chk(32'(dec[1].drv_sel), 32'(DRV_LOW_LEAK), "serial leak");
      chk(32'(dec[0].drv_sec), 32'(SEC_AVAIL), "ch0 back");
      chk(32'(dec[1].pmu_state), 32'(PMU_FNMV), "serial pmu");
      // A write with the clock enable low must not land
      @(posedge hclk);
      en <= 1'b0;
      bus(1'b1, CFG1_OFS, 32'h0);
      en <= 1'b1;
      bus(1'b0, CFG1_OFS, 32'h0);
      chk(rd, 32'h9, "frozen write");
      $display("test low leak done");
      for (int k = 0; k < 6; k++)
      begin
         req[0] <= {1'b1, drow[k][2:0]};
         bus(1'b1, CFG0_OFS, 32'h84 | (32'(drow[k][4:3]) << 5));
         settle();
         chk(32'(dec[0].drv_sel), 32'(dexp[k]), "drive mux");
         if (dexp[k] == DRV_HIZ_RCV)
            chk(32'({dec[0].clamps_on, dec[0].comparators_on}), 32'h3,
               "receive");
      end
      $display("test driver done");
      summarize();
   end
endmodule // pcm_decoder_tb_top
